/* src/tbcc_pkg.sv */
// package for the two-channel capture/compare timer: register map, field layout, reset values
package tbcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses on the register port)
  localparam logic [7:0] ADDR_STAT_CTRL = 8'h40;
  localparam logic [7:0] ADDR_CNT_HI = 8'h41;
  localparam logic [7:0] ADDR_CNT_LO = 8'h42;
  localparam logic [7:0] ADDR_LIM_HI = 8'h43;
  localparam logic [7:0] ADDR_LIM_LO = 8'h44;
  localparam logic [7:0] ADDR_CH0_SC = 8'h45;
  localparam logic [7:0] ADDR_CH0_VHI = 8'h46;
  localparam logic [7:0] ADDR_CH0_VLO = 8'h47;
  localparam logic [7:0] ADDR_CH1_SC = 8'h48;
  localparam logic [7:0] ADDR_CH1_VHI = 8'h49;
  localparam logic [7:0] ADDR_CH1_VLO = 8'h4A;

  ////////////////////////////////////////////////////////////////////////////////
  // timer status/control fields
  localparam int SC_ROLL_FLAG = 7;
  localparam int SC_ROLL_IE = 6;
  localparam int SC_HALT = 5;
  localparam int SC_CLEAR = 4;
  localparam int SC_PS_LSB = 0;

  // channel status/control fields
  localparam int CH_FLAG = 7;
  localparam int CH_IE = 6;
  localparam int CH_BUF = 5;
  localparam int CH_MSA = 4;
  localparam int CH_ELS_LSB = 2;
  localparam int CH_TOV = 1;
  localparam int CH_MAX = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // codes and reset values
  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_BOTH_SET = 2'h3;

  typedef struct packed {
    logic flag;
    logic arm;
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] els;
    logic tov;
    logic max;
    logic max_eff;
    logic [15:0] val;
    logic cmp_lock;
    logic cap_lock;
    logic out;
    logic oe;
    logic irq;
    logic [2:0] pin_s;
  } tbcc_chan_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [15:0] cnt;
    logic [15:0] lim;
    logic [5:0] pre;
    logic [2:0] ps;
    logic halt;
    logic roll_ie;
    logic roll_flag;
    logic roll_arm;
    logic lim_lock;
    logic lo_latched;
    logic [7:0] lo_latch;
    logic buf_sel;
    logic buf_pend;
    logic roll_irq;
    logic [2:0] ext_s;
    tbcc_chan_t [1:0] ch;
  } tbcc_state_t;

endpackage

/* src/tbcc_top.sv */
// two-channel capture/compare timer with prescaler, modulo limit and byte register port
//
// Function
// R1: halt plus clear in one write stops the counter at zero.
// R2: clock_source_select picks bus clock divided by 1..64, or external count clock.
// R3: reset clears clock_source_select, giving the undivided bus clock.
// R4: high-byte count read latches low byte until low byte is read.
// R5: count registers read-only, zero after reset and after counter_clear.
// R6: counter equal to limit sets rollover_flag; next tick restarts from zero.
// R7: limit high write suppresses rollover_flag and its request until low write.
// R8: reset sets every limit bit to one.
// R9: event flag set on capture edge, or on counter match in compare.
// R10: flag clears only by read-with-flag then write zero; new event wins.
// R11: channel_irq_enable gates the channel request; reset clears it.
// R12: buffered_select on channel 0 disables channel 1 register and pin.
// R13: with edge_level_select nonzero, mode_select_a picks compare (1) or capture (0).
// R14: with edge_level_select zero, mode_select_a presets output low (1) or high (0).
// R15: edge_level_select zero leaves pin to port; preset state kept; reset clears.
// R16: capture edges: 01 rising, 10 falling, 11 either.
// R17: compare actions: 01 toggle, 10 clear, 11 set.
// R18: toggle_on_rollover toggles compare output each rollover; no effect on capture.
// R19: rollover action beats compare action in the same cycle.
// R20: full_duty_force holds PWM at 100%, effective from next PWM cycle; code forces it only while toggle_on_rollover is clear.
// R21: the source holds a capture pin stable two clocks before capture enabling.
// R22: buffered_select links channels; channel 0 values control first.
// R23: counter_clear zeroes counter and prescaler, self-clears, reads zero.
// R24: counter increments on each selected clock tick while not halted.
`timescale 1ns/1ps

module tbcc_top (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic EXT_CLK_I,
  input wire logic [1:0] CH_PIN_I,
  output logic [7:0] RDATA_O,
  output logic [1:0] CH_PIN_O,
  output logic [1:0] CH_PIN_OE_O,
  output logic ROLL_IRQ_O,
  output logic [1:0] CH_IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // tick of the selected source; prescaler taps are all-ones of its low bits
  function automatic logic src_tick(input logic [2:0] ps, input logic [5:0] pre,
                                    input logic ext_rise);
    logic hit;
    hit = 1'b1;
    for (int k = 0; k < 6; k++) begin
      if (k < int'(ps) && !pre[k]) begin
        hit = 1'b0;
      end
    end
    if (ps == tbcc_pkg::PS_EXTERNAL) begin
      hit = ext_rise;
    end
    return hit;
  endfunction

  function automatic logic edge_hit(input logic [1:0] els, input logic prev, input logic cur);
    logic r;
    unique case (els)
      tbcc_pkg::ELS_RISE_TOGGLE: r = cur & ~prev;
      tbcc_pkg::ELS_FALL_CLEAR: r = ~cur & prev;
      tbcc_pkg::ELS_BOTH_SET: r = cur ^ prev;
      tbcc_pkg::ELS_OFF: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic cmp_action(input logic [1:0] els, input logic out);
    logic r;
    unique case (els)
      tbcc_pkg::ELS_RISE_TOGGLE: r = ~out;
      tbcc_pkg::ELS_FALL_CLEAR: r = 1'b0;
      tbcc_pkg::ELS_BOTH_SET: r = 1'b1;
      tbcc_pkg::ELS_OFF: r = out;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] chan_sc(input tbcc_pkg::tbcc_chan_t c);
    return {c.flag, c.ie, c.msb, c.msa, c.els, c.tov, c.max};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  tbcc_pkg::tbcc_state_t s_q;
  tbcc_pkg::tbcc_state_t s_d;

  logic tick;
  logic roll;
  logic wr_sc;
  logic clr_req;
  logic ext_rise;
  logic buffered;
  logic [1:0] ch_en;
  logic [1:0] is_cap;
  logic [1:0] is_cmp;
  logic [1:0] cap_ev;
  logic [1:0] cmp_ev;
  logic [1:0] roll_tg;
  logic [15:0] cmp_val;
  logic [7:0] sc_addr [2];
  logic [7:0] vhi_addr [2];
  logic [7:0] vlo_addr [2];

  assign sc_addr[0] = tbcc_pkg::ADDR_CH0_SC;
  assign sc_addr[1] = tbcc_pkg::ADDR_CH1_SC;
  assign vhi_addr[0] = tbcc_pkg::ADDR_CH0_VHI;
  assign vhi_addr[1] = tbcc_pkg::ADDR_CH1_VHI;
  assign vlo_addr[0] = tbcc_pkg::ADDR_CH0_VLO;
  assign vlo_addr[1] = tbcc_pkg::ADDR_CH1_VLO;

  always_comb begin
    s_d = s_q;

    // pin synchronisers: stage 0 feeds stage 1 only; stage 2 is the edge history
    s_d.ext_s = {s_q.ext_s[1:0], EXT_CLK_I};
    for (int i = 0; i < 2; i++) begin
      s_d.ch[i].pin_s = {s_q.ch[i].pin_s[1:0], CH_PIN_I[i]};
    end
    ext_rise = s_q.ext_s[1] & ~s_q.ext_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // counter and prescaler
    wr_sc = WR_I && ADDR_I == tbcc_pkg::ADDR_STAT_CTRL;
    clr_req = wr_sc && WDATA_I[tbcc_pkg::SC_CLEAR];
    tick = !s_q.halt && src_tick(s_q.ps, s_q.pre, ext_rise); // see R2 see R24
    roll = tick && s_q.cnt == s_q.lim;
    if (clr_req) begin
      s_d.cnt = tbcc_pkg::CNT_RESET; // see R23 see R5 see R1
      s_d.pre = '0;
    end else if (!s_q.halt) begin
      s_d.pre = s_q.pre + 6'h01;
      if (roll) begin
        s_d.cnt = tbcc_pkg::CNT_RESET; // see R6
      end else if (tick) begin
        s_d.cnt = s_q.cnt + 16'h0001; // see R24
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer status/control and limit writes
    if (wr_sc) begin
      s_d.roll_ie = WDATA_I[tbcc_pkg::SC_ROLL_IE];
      s_d.halt = WDATA_I[tbcc_pkg::SC_HALT]; // see R1
      s_d.ps = WDATA_I[tbcc_pkg::SC_PS_LSB +: 3]; // see R2
      s_d.roll_arm = 1'b0;
      if (!WDATA_I[tbcc_pkg::SC_ROLL_FLAG] && s_q.roll_arm) begin
        s_d.roll_flag = 1'b0;
      end
    end
    if (WR_I && ADDR_I == tbcc_pkg::ADDR_LIM_HI) begin
      s_d.lim[15:8] = WDATA_I;
      s_d.lim_lock = 1'b1; // see R7
    end
    if (WR_I && ADDR_I == tbcc_pkg::ADDR_LIM_LO) begin
      s_d.lim[7:0] = WDATA_I;
      s_d.lim_lock = 1'b0; // see R7
    end
    // the set wins over a clear in the same cycle
    if (roll && !s_q.lim_lock) begin
      s_d.roll_flag = 1'b1; // see R6 see R7
    end
    s_d.roll_irq = s_d.roll_flag && s_d.roll_ie;

    ////////////////////////////////////////////////////////////////////////////
    // channels
    buffered = s_q.ch[0].msb;
    // buffered pair swaps to the value written last at each rollover
    if (roll) begin
      s_d.buf_sel = s_q.buf_pend; // see R22
    end
    cmp_val = (buffered && s_q.buf_sel) ? s_q.ch[1].val : s_q.ch[0].val;
    ch_en[0] = 1'b1;
    ch_en[1] = !buffered; // see R12
    for (int i = 0; i < 2; i++) begin
      is_cap[i] = ch_en[i] && !s_q.ch[i].msb && !s_q.ch[i].msa &&
                  s_q.ch[i].els != tbcc_pkg::ELS_OFF; // see R13
      is_cmp[i] = ch_en[i] && (s_q.ch[i].msb || s_q.ch[i].msa) &&
                  s_q.ch[i].els != tbcc_pkg::ELS_OFF; // see R13
      // halt and a pending high-byte read both hold off captures
      cap_ev[i] = is_cap[i] && !s_q.halt && !s_q.ch[i].cap_lock &&
                  edge_hit(s_q.ch[i].els, s_q.ch[i].pin_s[2], s_q.ch[i].pin_s[1]); // see R16
      cmp_ev[i] = is_cmp[i] && tick && !s_q.ch[i].cmp_lock &&
                  s_q.cnt == (i == 0 ? cmp_val : s_q.ch[i].val); // see R9
      roll_tg[i] = is_cmp[i] && roll && s_q.ch[i].tov; // see R18

      // register writes
      if (WR_I && ADDR_I == sc_addr[i] && ch_en[i]) begin
        s_d.ch[i].ie = WDATA_I[tbcc_pkg::CH_IE]; // see R11
        s_d.ch[i].msb = (i == 0) ? WDATA_I[tbcc_pkg::CH_BUF] : 1'b0; // see R12
        s_d.ch[i].msa = WDATA_I[tbcc_pkg::CH_MSA];
        s_d.ch[i].els = WDATA_I[tbcc_pkg::CH_ELS_LSB +: 2];
        s_d.ch[i].tov = WDATA_I[tbcc_pkg::CH_TOV];
        s_d.ch[i].max = WDATA_I[tbcc_pkg::CH_MAX];
        s_d.ch[i].arm = 1'b0;
        if (!WDATA_I[tbcc_pkg::CH_FLAG] && s_q.ch[i].arm) begin
          s_d.ch[i].flag = 1'b0; // see R10
        end
      end
      if (WR_I && ADDR_I == vhi_addr[i]) begin
        s_d.ch[i].val[15:8] = WDATA_I;
        s_d.ch[i].cmp_lock = 1'b1;
      end
      if (WR_I && ADDR_I == vlo_addr[i]) begin
        s_d.ch[i].val[7:0] = WDATA_I;
        s_d.ch[i].cmp_lock = 1'b0;
        s_d.buf_pend = (i == 1); // see R22
      end
      if (RD_I && ADDR_I == vhi_addr[i] && is_cap[i]) begin
        s_d.ch[i].cap_lock = 1'b1;
      end
      if (RD_I && ADDR_I == vlo_addr[i]) begin
        s_d.ch[i].cap_lock = 1'b0;
      end
      if (cap_ev[i]) begin
        s_d.ch[i].val = s_q.cnt;
      end
      if (cap_ev[i] || cmp_ev[i]) begin
        s_d.ch[i].flag = 1'b1; // see R9 see R10
      end

      // full duty only changes at a PWM cycle boundary
      if (roll) begin
        s_d.ch[i].max_eff = s_q.ch[i].max; // see R20
      end

      // output level
      if (s_q.ch[i].els == tbcc_pkg::ELS_OFF) begin
        s_d.ch[i].out = !s_q.ch[i].msa; // see R14 see R15
      end else if (is_cmp[i] && s_q.ch[i].max_eff && !s_q.ch[i].tov) begin
        s_d.ch[i].out = 1'b1; // see R20
      end else if (roll_tg[i]) begin
        s_d.ch[i].out = ~s_q.ch[i].out; // see R18 see R19
      end else if (cmp_ev[i]) begin
        s_d.ch[i].out = cmp_action(s_q.ch[i].els, s_q.ch[i].out); // see R17
      end
      s_d.ch[i].oe = ch_en[i] && is_cmp[i]; // see R15 see R12
      s_d.ch[i].irq = s_d.ch[i].flag && s_d.ch[i].ie; // see R11
    end

    ////////////////////////////////////////////////////////////////////////////
    // reads; data stands only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        tbcc_pkg::ADDR_STAT_CTRL: begin
          s_d.rdata = {s_q.roll_flag, s_q.roll_ie, s_q.halt, 2'b00, s_q.ps}; // see R23
          s_d.roll_arm = s_q.roll_flag;
        end
        tbcc_pkg::ADDR_CNT_HI: begin
          s_d.rdata = s_q.cnt[15:8];
          if (!s_q.lo_latched) begin
            s_d.lo_latch = s_q.cnt[7:0]; // see R4
            s_d.lo_latched = 1'b1;
          end
        end
        tbcc_pkg::ADDR_CNT_LO: begin
          s_d.rdata = s_q.lo_latched ? s_q.lo_latch : s_q.cnt[7:0]; // see R4
          s_d.lo_latched = 1'b0;
        end
        tbcc_pkg::ADDR_LIM_HI: s_d.rdata = s_q.lim[15:8];
        tbcc_pkg::ADDR_LIM_LO: s_d.rdata = s_q.lim[7:0];
        tbcc_pkg::ADDR_CH0_SC: begin
          s_d.rdata = chan_sc(s_q.ch[0]);
          s_d.ch[0].arm = s_q.ch[0].flag; // see R10
        end
        tbcc_pkg::ADDR_CH1_SC: begin
          if (ch_en[1]) begin
            s_d.rdata = chan_sc(s_q.ch[1]);
            s_d.ch[1].arm = s_q.ch[1].flag; // see R10
          end
        end
        tbcc_pkg::ADDR_CH0_VHI: s_d.rdata = s_q.ch[0].val[15:8];
        tbcc_pkg::ADDR_CH0_VLO: s_d.rdata = s_q.ch[0].val[7:0];
        tbcc_pkg::ADDR_CH1_VHI: s_d.rdata = s_q.ch[1].val[15:8];
        tbcc_pkg::ADDR_CH1_VLO: s_d.rdata = s_q.ch[1].val[7:0];
        default: s_d.rdata = 8'h00;
      endcase
    end
    // counter_clear drops any half-done count read
    if (clr_req) begin
      s_d.lo_latched = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_q <= '0;
      s_q.cnt <= tbcc_pkg::CNT_RESET; // see R5
      s_q.lim <= tbcc_pkg::LIMIT_RESET; // see R8
      s_q.ps <= tbcc_pkg::PS_RESET; // see R3
      s_q.halt <= tbcc_pkg::HALT_RESET;
      s_q.ch[0].out <= 1'b1;
      s_q.ch[1].out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata;
  assign CH_PIN_O = {s_q.ch[1].out, s_q.ch[0].out};
  assign CH_PIN_OE_O = {s_q.ch[1].oe, s_q.ch[0].oe};
  assign ROLL_IRQ_O = s_q.roll_irq;
  assign CH_IRQ_O = {s_q.ch[1].irq, s_q.ch[0].irq};

endmodule

/* verification/tbcc_pin_model.sv */
// model of the pins around the timer: external count clock and channel pins
`timescale 1ns/1ps
module tbcc_pin_model (
  input wire logic clk_i,
  input wire logic [1:0] dut_out_i,
  input wire logic [1:0] dut_oe_i,
  output logic ext_clk_o,
  output logic [1:0] pin_o
);
  logic [1:0] lvl_q = 2'b00;
  initial ext_clk_o = 1'b0;
  // a driven pin shows the timer level, an undriven one the source level
  assign pin_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & lvl_q);
  ////////////////////////////////////////
  // level set, then held three bus clocks (the sync and capture delay) before the task returns
  task automatic set_pin(input int ch, input logic lv);
    @(posedge clk_i);
    lvl_q[ch] <= lv;
    repeat (3) @(posedge clk_i);
  endtask
  // pulses two bus clocks wide, shifted off the bus edge; idle low between
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #30 ext_clk_o = 1'b1;
      repeat (2) @(posedge clk_i);
      #30 ext_clk_o = 1'b0;
      @(posedge clk_i);
    end
  endtask
endmodule

/* verification/tbcc_top_props.sv */
// assertion checker bound to the timer top ports
`timescale 1ns/1ps
module tbcc_top_props (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic EXT_CLK_I,
  input wire logic [1:0] CH_PIN_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [1:0] CH_PIN_O,
  input wire logic [1:0] CH_PIN_OE_O,
  input wire logic ROLL_IRQ_O,
  input wire logic [1:0] CH_IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);
  logic w40;
  logic w45;
  logic w48;
  assign w40 = WR_I && ADDR_I == 8'h40;
  assign w45 = WR_I && ADDR_I == 8'h45;
  assign w48 = WR_I && ADDR_I == 8'h48;
  ////////////////////////////////////////
  AST_RDATA_IDLE: assert property (
    !$past(RD_I) |-> RDATA_O == 8'h00) else $error("read data outside its slot");
  AST_CLEAR_READS_ZERO: assert property (
    $past(RD_I && ADDR_I == 8'h40) |-> RDATA_O[4:3] == 2'h0) else $error("clear bit reads one");
  AST_HALT_CLEAR_ZERO: assert property (
    (w40 && WDATA_I[5:4] == 2'h3) ##1 !WR_I ##1 (RD_I && ADDR_I == 8'h41)
    |=> RDATA_O == 8'h00) else $error("count not zero after halt and clear");
  // flags only drop through a register write, never on their own
  AST_CH0_FLAG_CLEAR: assert property (
    $fell(CH_IRQ_O[0]) |-> $past(w45) || $past(w45, 2)) else $error("channel flag lost");
  AST_ROLL_FLAG_CLEAR: assert property (
    $fell(ROLL_IRQ_O) |-> $past(w40) || $past(w40, 2)) else $error("rollover flag lost");
  AST_OE0_RISE: assert property (
    $rose(CH_PIN_OE_O[0]) |-> $past(w45) || $past(w45, 2)) else $error("pin 0 drive unasked");
  AST_OE0_FALL: assert property (
    $fell(CH_PIN_OE_O[0]) |-> $past(w45) || $past(w45, 2)) else $error("pin 0 released unasked");
  AST_OE1_LINK: assert property (
    $changed(CH_PIN_OE_O[1]) |-> $past(w45 || w48) || $past(w45 || w48, 2))
    else $error("pin 1 drive changed unasked");
endmodule
bind tbcc_top tbcc_top_props u_props (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .EXT_CLK_I(EXT_CLK_I),
  .CH_PIN_I(CH_PIN_I), .RDATA_O(RDATA_O), .CH_PIN_O(CH_PIN_O), .CH_PIN_OE_O(CH_PIN_OE_O),
  .ROLL_IRQ_O(ROLL_IRQ_O), .CH_IRQ_O(CH_IRQ_O));

/* verification/tbcc_top_tb_top.sv */
// self-checking testbench for the capture/compare timer
`timescale 1ns/1ps
module tbcc_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_clk;
  logic [1:0] pin_in;
  logic [7:0] rdata;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  logic roll_irq;
  logic [1:0] ch_irq;
  int errors = 0;
  int checks_done = 0;
  int seed = 54;
  int t;
  logic [7:0] b;
  logic [7:0] l0;
  logic [15:0] v;
  logic [7:0] ra [8] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h48, 8'h4B};
  logic [7:0] rv [8] = '{8'h20, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  always #50 clk = ~clk;
  tbcc_top DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .EXT_CLK_I(ext_clk), .CH_PIN_I(pin_in), .RDATA_O(rdata), .CH_PIN_O(pin_o),
    .CH_PIN_OE_O(pin_oe), .ROLL_IRQ_O(roll_irq), .CH_IRQ_O(ch_irq));
  tbcc_pin_model u_pin (.clk_i(clk), .dut_out_i(pin_o), .dut_oe_i(pin_oe),
    .ext_clk_o(ext_clk), .pin_o(pin_in));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdcnt(output logic [15:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rdr(8'h41, h);
    rdr(8'h42, l);
    c = {h, l};
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ra[7] = 8'h4B + (8'($random(seed)) & 8'h3F);
    for (int i = 0; i < 8; i++) begin
      rdr(ra[i], b);
      chk("reset_value", 16'(b), 16'(rv[i]));
    end
    wrr(8'h41, 8'($random(seed)));
    wrr(8'h42, 8'($random(seed)));
    rdcnt(v);
    chk("count_readonly", v, 16'h0000);
    done("reset");
    for (int ps = 0; ps < 7; ps++) begin
      wrr(8'h40, 8'h30);
      wrr(8'h40, 8'(ps));
      repeat (640) @(posedge clk);
      wrr(8'h40, 8'h20 | 8'(ps));
      rdcnt(v);
      t = 642 >> ps;
      chk("tick_rate", 16'(v >= 16'(t - 2) && v <= 16'(t + 2)), 16'h0001);
    end
    wrr(8'h40, 8'h37);
    wrr(8'h40, 8'h07);
    u_pin.ext_pulses(20);
    repeat (6) @(posedge clk);
    wrr(8'h40, 8'h27);
    rdcnt(v);
    chk("ext_count", v, 16'h0014);
    wrr(8'h40, 8'h30);
    rdcnt(v);
    chk("halt_clear", v, 16'h0000);
    done("clock");
    wrr(8'h40, 8'h00);
    repeat (100) @(posedge clk);
    wrr(8'h40, 8'h20);
    rdr(8'h42, l0);
    rdr(8'h41, b);
    wrr(8'h40, 8'h00);
    repeat (50) @(posedge clk);
    wrr(8'h40, 8'h20);
    rdr(8'h41, b);
    rdr(8'h42, b);
    chk("latched_low", 16'(b), 16'(l0));
    done("latch");
    wrr(8'h40, 8'h30);
    wrr(8'h43, 8'h00);
    wrr(8'h44, 8'h09);
    wrr(8'h40, 8'h40);
    repeat (30) @(posedge clk);
    wrr(8'h40, 8'h60);
    settle;
    chk("roll_irq", 16'(roll_irq), 16'h0001);
    rdcnt(v);
    chk("count_limit", 16'(v <= 16'h0009), 16'h0001);
    rdr(8'h40, b);
    wrr(8'h40, 8'h60);
    settle;
    chk("roll_cleared", 16'(roll_irq), 16'h0000);
    wrr(8'h40, 8'h70);
    wrr(8'h43, 8'h00);
    wrr(8'h40, 8'h40);
    repeat (30) @(posedge clk);
    chk("roll_locked", 16'(roll_irq), 16'h0000);
    wrr(8'h44, 8'h09);
    repeat (30) @(posedge clk);
    chk("roll_unlocked", 16'(roll_irq), 16'h0001);
    done("rollover");
    wrr(8'h40, 8'h30);
    wrr(8'h43, 8'hFF);
    wrr(8'h44, 8'hFF);
    wrr(8'h40, 8'h00);
    for (int c = 1; c < 4; c++) begin
      wrr(8'h45, 8'h40 | 8'(c << 2));
      u_pin.set_pin(0, 1'b1);
      settle;
      chk("cap_rise", 16'(ch_irq[0]), 16'(c & 1));
      rdr(8'h45, b);
      wrr(8'h45, 8'h40 | 8'(c << 2));
      settle;
      chk("flag_clear", 16'(ch_irq[0]), 16'h0000);
      u_pin.set_pin(0, 1'b0);
      settle;
      chk("cap_fall", 16'(ch_irq[0]), 16'(c >> 1));
      rdr(8'h45, b);
      wrr(8'h45, 8'h00);
    end
    wrr(8'h45, 8'h0C);
    u_pin.set_pin(0, 1'b1);
    settle;
    chk("irq_masked", 16'(ch_irq[0]), 16'h0000);
    rdr(8'h45, b);
    chk("flag_seen", 16'(b[7]), 16'h0001);
    wrr(8'h45, 8'h0C);
    done("capture");
    wrr(8'h40, 8'h30);
    wrr(8'h43, 8'h00);
    wrr(8'h44, 8'h20);
    wrr(8'h46, 8'h00);
    wrr(8'h47, 8'h10);
    for (int c = 1; c < 4; c++) begin
      wrr(8'h40, 8'h30);
      wrr(8'h45, 8'h10);
      settle;
      chk("preset_low", {14'h0000, pin_oe[0], pin_o[0]}, 16'h0000);
      wrr(8'h45, 8'h10 | 8'(c << 2));
      settle;
      chk("drive_on", 16'(pin_oe[0]), 16'h0001);
      wrr(8'h40, 8'h00);
      repeat (20) @(posedge clk);
      wrr(8'h40, 8'h20);
      settle;
      chk("cmp_out", 16'(pin_o[0]), 16'(c != 2));
      rdr(8'h45, b);
      chk("cmp_flag", 16'(b[7]), 16'h0001);
      wrr(8'h45, 8'h10);
    end
    wrr(8'h45, 8'h00);
    settle;
    chk("preset_high", 16'(pin_o[0]), 16'h0001);
    wrr(8'h40, 8'h30);
    wrr(8'h47, 8'h20);
    wrr(8'h45, 8'h10);
    wrr(8'h45, 8'h1A);
    wrr(8'h40, 8'h00);
    repeat (40) @(posedge clk);
    wrr(8'h40, 8'h20);
    settle;
    chk("roll_wins", 16'(pin_o[0]), 16'h0001);
    done("compare");
    wrr(8'h45, 8'h00);
    wrr(8'h48, 8'h54);
    rdr(8'h48, b);
    chk("ch1_ctrl", 16'(b), 16'h0054);
    wrr(8'h45, 8'h20);
    wrr(8'h48, 8'h50);
    rdr(8'h48, b);
    settle;
    chk("ch1_hidden", {b, 7'h00, pin_oe[1]}, 16'h0000);
    chk("ch1_irq", 16'(ch_irq[1]), 16'h0000);
    wrr(8'h45, 8'h00);
    done("buffered");
    complete_run;
  end
endmodule
